// [core/ovl_pkg.sv]
// Constants for the per-channel output voltage set-point and limit bank.
// Assumes a command decoder upstream that delivers whole command words.
//
// Summary of operation
// - Format byte read-only: 3-bit mode, 5-bit exponent
// - Format byte reads 0x14, exponent two to minus twelve
// - Commanded voltage never exceeds ceiling; ceiling max 5.7V
// - Sense voltage above fault threshold declares overvoltage
// - New overvoltage threshold applied within 10ms while switching
// - Busy bits 5 and 6 low while recalculating
// - Pull-down response keeps fault pin quiet on overvoltage
// - Overvoltage drops top gate, raises bottom gate
// - Readback above warning sets status bits, alert
// - Readback below warning sets status bits, alert
// - Warnings come from converter measurements, within 120ms
// - Sense voltage below fault threshold declares undervoltage
// - Margin-high mode regulates to margin-up set-point
// - Margin-low mode regulates to margin-down set-point
// - Nominal set-point sets regulated output voltage
// - Set-point changes ignored during rise and fall
// - Steady-state set-point changes ramp at transition rate
// - Absolute ceiling 5.7V high range, 2.75V low
// - Nominal above absolute ceiling: logic fault, clamped
// - Quiescent offset per channel, default 0.050 A

package ovl_pkg;

	// ----------------------------------------------------------------
	// Command codes
	// ----------------------------------------------------------------
	localparam logic [7:0] OVL_CMD_FORMAT = 8'h20;
	localparam logic [7:0] OVL_CMD_NOMINAL = 8'h21;
	localparam logic [7:0] OVL_CMD_CEILING = 8'h24;
	localparam logic [7:0] OVL_CMD_MARGIN_UP = 8'h25;
	localparam logic [7:0] OVL_CMD_MARGIN_DOWN = 8'h26;
	localparam logic [7:0] OVL_CMD_OV_FAULT = 8'h40;
	localparam logic [7:0] OVL_CMD_OV_WARN = 8'h42;
	localparam logic [7:0] OVL_CMD_UV_WARN = 8'h43;
	localparam logic [7:0] OVL_CMD_UV_FAULT = 8'h44;
	localparam logic [7:0] OVL_CMD_ABS_CEILING = 8'ha5;
	localparam logic [7:0] OVL_CMD_IIN_OFFSET = 8'he9;

	// ----------------------------------------------------------------
	// Reset values
	// ----------------------------------------------------------------
	localparam logic [15:0] OVL_RST_NOMINAL = 16'h1000;
	localparam logic [15:0] OVL_RST_CEILING = 16'h599a;
	localparam logic [15:0] OVL_RST_MARGIN_UP = 16'h10cd;
	localparam logic [15:0] OVL_RST_MARGIN_DOWN = 16'h0f33;
	localparam logic [15:0] OVL_RST_OV_FAULT = 16'h119a;
	localparam logic [15:0] OVL_RST_OV_WARN = 16'h1133;
	localparam logic [15:0] OVL_RST_UV_WARN = 16'h0ecd;
	localparam logic [15:0] OVL_RST_UV_FAULT = 16'h0e66;
	localparam logic [15:0] OVL_RST_IIN_OFFSET = 16'h9333;

	// ----------------------------------------------------------------
	// Format byte fields and fixed limits
	// ----------------------------------------------------------------
	localparam logic [2:0] OVL_FMT_MODE_LINEAR = 3'h0;
	localparam logic [4:0] OVL_FMT_EXPONENT = 5'h14;
	localparam int OVL_FMT_MODE_POS = 5;
	localparam logic [15:0] OVL_ABS_CEIL_HIGH = 16'h5b33;
	localparam logic [15:0] OVL_ABS_CEIL_LOW = 16'h2c00;
	localparam int OVL_RANGE_BIT = 1;
	localparam int OVL_BUSY_BIT_A = 5;
	localparam int OVL_BUSY_BIT_B = 6;
	localparam int OVL_CHANNELS = 2;

	// ----------------------------------------------------------------
	// Timing
	// ----------------------------------------------------------------
	localparam int OVL_CLK_HZ = 25000000;
	localparam int OVL_OV_APPLY_MS = 10;
	localparam int OVL_OV_APPLY_CYC = OVL_CLK_HZ / 1000 * OVL_OV_APPLY_MS;
	localparam int OVL_WARN_RESP_MS = 120;
	localparam int OVL_WARN_RESP_CYC = OVL_CLK_HZ / 1000 * OVL_WARN_RESP_MS;

	typedef enum logic [1:0] {
		OVL_OP_NOMINAL = 2'b00,
		OVL_OP_MARGIN_LOW = 2'b01,
		OVL_OP_MARGIN_HIGH = 2'b10
	} ovl_op_e;

endpackage

// [core/ovl_regs.sv]
// Per-channel output voltage set-point, ceiling and limit command bank.
// Assumes an upstream bus engine hands over decoded command words and the
// active page; converter measurements arrive already scaled as 16-bit
// unsigned words with the fixed two to minus twelve exponent.

`timescale 1ns/100ps

module ovl_regs
	import ovl_pkg::*;
#(
	parameter int OV_APPLY_CYC = OVL_OV_APPLY_CYC
) (
	input wire logic ref_clk,
	input wire logic resetn,
	input wire logic ce,
	input wire logic cmd_valid,
	input wire logic cmd_write,
	input wire logic [7:0] cmd_code,
	input wire logic cmd_page,
	input wire logic [15:0] cmd_wdata,
	output logic [15:0] cmd_rdata,
	output logic cmd_ack,
	output logic cmd_err,
	output logic cml_fault,
	input wire logic [1:0] pwm_mode_config_range,
	input wire logic [1:0] op_mode_0,
	input wire logic [1:0] op_mode_1,
	input wire logic [1:0] seq_ramping,
	input wire logic [1:0] out_active,
	input wire logic [1:0] switching_active,
	input wire logic [15:0] ramp_step,
	input wire logic [1:0] overvolt_pulldown_response,
	input wire logic [15:0] sense_volt_0,
	input wire logic [15:0] sense_volt_1,
	input wire logic [15:0] readback_volt_0,
	input wire logic [15:0] readback_volt_1,
	input wire logic [1:0] readback_valid,
	input wire logic [1:0] pwm_top,
	input wire logic [1:0] pwm_bot,
	input wire logic clear_status,
	input wire logic [1:0] alert_mask,
	output logic [15:0] vout_target_0,
	output logic [15:0] vout_target_1,
	output logic [15:0] iin_offset_0,
	output logic [15:0] iin_offset_1,
	output logic [7:0] common_mfr_status,
	output logic [1:0] ov_fault,
	output logic [1:0] uv_fault,
	output logic [1:0] top_gate_drive,
	output logic [1:0] bottom_gate_drive,
	output logic fault_pin_n,
	output logic [1:0] status_other,
	output logic [1:0] status_vout,
	output logic [1:0] ov_warn,
	output logic [1:0] uv_warn,
	output logic alert_n
);

	// ----------------------------------------------------------------
	// Storage, one copy per channel
	// ----------------------------------------------------------------
	logic [15:0] nominal_reg [OVL_CHANNELS];
	logic [15:0] ceiling_reg [OVL_CHANNELS];
	logic [15:0] margin_up_reg [OVL_CHANNELS];
	logic [15:0] margin_down_reg [OVL_CHANNELS];
	logic [15:0] ov_fault_reg [OVL_CHANNELS];
	logic [15:0] ov_applied_reg [OVL_CHANNELS];
	logic [15:0] ov_warn_reg [OVL_CHANNELS];
	logic [15:0] uv_warn_reg [OVL_CHANNELS];
	logic [15:0] uv_fault_reg [OVL_CHANNELS];
	logic [15:0] iin_offset_reg [OVL_CHANNELS];
	logic [15:0] goal_reg [OVL_CHANNELS];
	logic [15:0] target_reg [OVL_CHANNELS];
	logic [17:0] busy_cnt_reg [OVL_CHANNELS];
	logic [1:0] busy_reg;
	logic [15:0] sense [OVL_CHANNELS];
	logic [15:0] readback [OVL_CHANNELS];
	logic [1:0] op_mode [OVL_CHANNELS];
	logic [15:0] abs_ceil [OVL_CHANNELS];
	logic [15:0] goal_next [OVL_CHANNELS];
	logic [15:0] wr_clamped;
	logic [15:0] rd_next;
	logic known;
	logic wr;
	logic rd;
	logic pg;
	logic [1:0] ov_det;
	logic [1:0] uv_det;
	logic [1:0] ov_hit;
	logic [1:0] uv_hit;

	assign sense[0] = sense_volt_0;
	assign sense[1] = sense_volt_1;
	assign readback[0] = readback_volt_0;
	assign readback[1] = readback_volt_1;
	assign op_mode[0] = op_mode_0;
	assign op_mode[1] = op_mode_1;
	assign wr = cmd_valid & cmd_write;
	assign rd = cmd_valid & ~cmd_write;
	assign pg = cmd_page;
	assign vout_target_0 = target_reg[0];
	assign vout_target_1 = target_reg[1];
	assign iin_offset_0 = iin_offset_reg[0];
	assign iin_offset_1 = iin_offset_reg[1];

	// ----------------------------------------------------------------
	// Per-channel derived values
	// ----------------------------------------------------------------
	// Absolute ceiling follows range bit; margin choice then ceiling cap
	always_comb begin
		for (int c = 0; c < OVL_CHANNELS; c++) begin
			abs_ceil[c] = pwm_mode_config_range[c] ? OVL_ABS_CEIL_LOW :
				OVL_ABS_CEIL_HIGH;
			if (op_mode[c] == OVL_OP_MARGIN_HIGH) begin
				goal_next[c] = margin_up_reg[c];
			end else if (op_mode[c] == OVL_OP_MARGIN_LOW) begin
				goal_next[c] = margin_down_reg[c];
			end else begin
				goal_next[c] = nominal_reg[c];
			end
			if (goal_next[c] > ceiling_reg[c]) begin
				goal_next[c] = ceiling_reg[c];
			end
			ov_det[c] = sense[c] > ov_applied_reg[c];
			uv_det[c] = sense[c] < uv_fault_reg[c];
			ov_hit[c] = readback_valid[c] & (readback[c] > ov_warn_reg[c]);
			uv_hit[c] = readback_valid[c] & (readback[c] < uv_warn_reg[c]);
		end
	end

	// ----------------------------------------------------------------
	// Command decode
	// ----------------------------------------------------------------
	// Write data limited per register before storing
	always_comb begin
		wr_clamped = cmd_wdata;
		if (cmd_code == OVL_CMD_CEILING && cmd_wdata > OVL_ABS_CEIL_HIGH) begin
			wr_clamped = OVL_ABS_CEIL_HIGH;
		end else if (cmd_code == OVL_CMD_NOMINAL &&
			cmd_wdata > abs_ceil[pg]) begin
			wr_clamped = abs_ceil[pg];
		end
	end

	// Read mux; the page picks the channel copy
	always_comb begin
		rd_next = 16'h0000;
		known = 1'b1;
		if (cmd_code == OVL_CMD_FORMAT) begin
			rd_next = {8'h00, OVL_FMT_MODE_LINEAR, OVL_FMT_EXPONENT};
		end else if (cmd_code == OVL_CMD_NOMINAL) begin
			rd_next = nominal_reg[pg];
		end else if (cmd_code == OVL_CMD_CEILING) begin
			rd_next = ceiling_reg[pg];
		end else if (cmd_code == OVL_CMD_MARGIN_UP) begin
			rd_next = margin_up_reg[pg];
		end else if (cmd_code == OVL_CMD_MARGIN_DOWN) begin
			rd_next = margin_down_reg[pg];
		end else if (cmd_code == OVL_CMD_OV_FAULT) begin
			rd_next = ov_fault_reg[pg];
		end else if (cmd_code == OVL_CMD_OV_WARN) begin
			rd_next = ov_warn_reg[pg];
		end else if (cmd_code == OVL_CMD_UV_WARN) begin
			rd_next = uv_warn_reg[pg];
		end else if (cmd_code == OVL_CMD_UV_FAULT) begin
			rd_next = uv_fault_reg[pg];
		end else if (cmd_code == OVL_CMD_ABS_CEILING) begin
			rd_next = abs_ceil[pg];
		end else if (cmd_code == OVL_CMD_IIN_OFFSET) begin
			rd_next = iin_offset_reg[pg];
		end else begin
			known = 1'b0;
		end
	end

	// Answer one cycle after the request; words go out whole, the bus
	// engine sends the low byte first
	always_ff @(posedge ref_clk) begin
		if (!resetn) begin
			cmd_rdata <= 16'h0000;
			cmd_ack <= 1'b0;
			cmd_err <= 1'b0;
		end else if (ce) begin
			cmd_ack <= cmd_valid;
			cmd_err <= cmd_valid & (~known | (cmd_write &
				(cmd_code == OVL_CMD_FORMAT ||
				cmd_code == OVL_CMD_ABS_CEILING)));
			if (rd) begin
				cmd_rdata <= rd_next;
			end
		end
	end

	// Logic fault pulse for a nominal write over the absolute ceiling
	always_ff @(posedge ref_clk) begin
		if (!resetn) begin
			cml_fault <= 1'b0;
		end else if (ce) begin
			cml_fault <= wr && cmd_code == OVL_CMD_NOMINAL &&
				cmd_wdata > abs_ceil[pg];
		end
	end

	// ----------------------------------------------------------------
	// Register writes
	// ----------------------------------------------------------------
	always_ff @(posedge ref_clk) begin
		if (!resetn) begin
			for (int c = 0; c < OVL_CHANNELS; c++) begin
				nominal_reg[c] <= OVL_RST_NOMINAL;
				ceiling_reg[c] <= OVL_RST_CEILING;
				margin_up_reg[c] <= OVL_RST_MARGIN_UP;
				margin_down_reg[c] <= OVL_RST_MARGIN_DOWN;
				ov_fault_reg[c] <= OVL_RST_OV_FAULT;
				ov_warn_reg[c] <= OVL_RST_OV_WARN;
				uv_warn_reg[c] <= OVL_RST_UV_WARN;
				uv_fault_reg[c] <= OVL_RST_UV_FAULT;
				iin_offset_reg[c] <= OVL_RST_IIN_OFFSET;
			end
		end else if (ce && wr) begin
			if (cmd_code == OVL_CMD_NOMINAL) begin
				nominal_reg[pg] <= wr_clamped;
			end else if (cmd_code == OVL_CMD_CEILING) begin
				ceiling_reg[pg] <= wr_clamped;
			end else if (cmd_code == OVL_CMD_MARGIN_UP) begin
				margin_up_reg[pg] <= cmd_wdata;
			end else if (cmd_code == OVL_CMD_MARGIN_DOWN) begin
				margin_down_reg[pg] <= cmd_wdata;
			end else if (cmd_code == OVL_CMD_OV_FAULT) begin
				ov_fault_reg[pg] <= cmd_wdata;
			end else if (cmd_code == OVL_CMD_OV_WARN) begin
				ov_warn_reg[pg] <= cmd_wdata;
			end else if (cmd_code == OVL_CMD_UV_WARN) begin
				uv_warn_reg[pg] <= cmd_wdata;
			end else if (cmd_code == OVL_CMD_UV_FAULT) begin
				uv_fault_reg[pg] <= cmd_wdata;
			end else if (cmd_code == OVL_CMD_IIN_OFFSET) begin
				iin_offset_reg[pg] <= cmd_wdata;
			end
		end
	end

	// ----------------------------------------------------------------
	// Overvoltage threshold recalculation
	// ----------------------------------------------------------------
	// While switching, the new threshold waits out the full delay so a
	// host that polls busy never sees a half-applied limit
	always_ff @(posedge ref_clk) begin
		if (!resetn) begin
			for (int c = 0; c < OVL_CHANNELS; c++) begin
				ov_applied_reg[c] <= OVL_RST_OV_FAULT;
				busy_cnt_reg[c] <= 18'h00000;
			end
			busy_reg <= 2'b00;
		end else if (ce) begin
			for (int c = 0; c < OVL_CHANNELS; c++) begin
				if (wr && cmd_code == OVL_CMD_OV_FAULT && pg == c[0]) begin
					if (switching_active[c]) begin
						busy_reg[c] <= 1'b1;
						busy_cnt_reg[c] <= 18'(OV_APPLY_CYC - 1);
					end else begin
						ov_applied_reg[c] <= cmd_wdata;
						busy_reg[c] <= 1'b0;
					end
				end else if (busy_reg[c]) begin
					if (busy_cnt_reg[c] == 18'h00000) begin
						ov_applied_reg[c] <= ov_fault_reg[c];
						busy_reg[c] <= 1'b0;
					end else begin
						busy_cnt_reg[c] <= busy_cnt_reg[c] - 18'h00001;
					end
				end
			end
		end
	end

	// Busy shows low on both status bits; other bits are not ours
	always_comb begin
		common_mfr_status = 8'h00;
		common_mfr_status[OVL_BUSY_BIT_A] = ~(|busy_reg);
		common_mfr_status[OVL_BUSY_BIT_B] = ~(|busy_reg);
	end

	// ----------------------------------------------------------------
	// Set-point goal and ramp
	// ----------------------------------------------------------------
	// Goal frozen during rise and fall; steady state steps at ramp rate
	always_ff @(posedge ref_clk) begin
		if (!resetn) begin
			for (int c = 0; c < OVL_CHANNELS; c++) begin
				goal_reg[c] <= OVL_RST_NOMINAL;
				target_reg[c] <= OVL_RST_NOMINAL;
			end
		end else if (ce) begin
			for (int c = 0; c < OVL_CHANNELS; c++) begin
				if (!seq_ramping[c]) begin
					goal_reg[c] <= goal_next[c];
				end
				if (!out_active[c] || seq_ramping[c]) begin
					target_reg[c] <= goal_reg[c];
				end else if (target_reg[c] < goal_reg[c]) begin
					target_reg[c] <= (goal_reg[c] - target_reg[c] > ramp_step) ?
						target_reg[c] + ramp_step : goal_reg[c];
				end else if (target_reg[c] > goal_reg[c]) begin
					target_reg[c] <= (target_reg[c] - goal_reg[c] > ramp_step) ?
						target_reg[c] - ramp_step : goal_reg[c];
				end
			end
		end
	end

	// ----------------------------------------------------------------
	// Faults and gate drive
	// ----------------------------------------------------------------
	// One cycle from sense compare to gate override
	always_ff @(posedge ref_clk) begin
		if (!resetn) begin
			ov_fault <= 2'b00;
			uv_fault <= 2'b00;
			top_gate_drive <= 2'b00;
			bottom_gate_drive <= 2'b00;
			fault_pin_n <= 1'b1;
		end else if (ce) begin
			ov_fault <= ov_det;
			uv_fault <= uv_det;
			top_gate_drive <= pwm_top & ~ov_det;
			bottom_gate_drive <= pwm_bot | ov_det;
			fault_pin_n <= ~(|(ov_det & ~overvolt_pulldown_response) |
				|uv_det);
		end
	end

	// ----------------------------------------------------------------
	// Warnings and alert
	// ----------------------------------------------------------------
	// Sticky; a new hit in the clear cycle wins so no event is lost
	always_ff @(posedge ref_clk) begin
		if (!resetn) begin
			ov_warn <= 2'b00;
			uv_warn <= 2'b00;
			status_vout <= 2'b00;
			status_other <= 2'b00;
		end else if (ce) begin
			ov_warn <= (clear_status ? 2'b00 : ov_warn) | ov_hit;
			uv_warn <= (clear_status ? 2'b00 : uv_warn) | uv_hit;
			status_vout <= (clear_status ? 2'b00 : status_vout) |
				ov_hit | uv_hit;
			status_other <= (clear_status ? 2'b00 : status_other) |
				ov_hit | uv_hit;
		end
	end

	// Alert pin follows unmasked warning flags
	always_ff @(posedge ref_clk) begin
		if (!resetn) begin
			alert_n <= 1'b1;
		end else if (ce) begin
			alert_n <= ~(|(((ov_warn | uv_warn) & ~alert_mask) |
				((ov_hit | uv_hit) & ~alert_mask)));
		end
	end

endmodule

// [tb/ovl_host.sv]
// Command host model for the limit bank: one request, one answer.
// Assumes the one-cycle request pulse and next-edge ack of the bank.
`timescale 1ns/100ps

module ovl_host (
	input wire logic ref_clk,
	output logic cmd_valid,
	output logic cmd_write,
	output logic [7:0] cmd_code,
	output logic cmd_page,
	output logic [15:0] cmd_wdata,
	input wire logic [15:0] cmd_rdata,
	input wire logic cmd_ack,
	input wire logic cmd_err,
	input wire logic [7:0] common_mfr_status
);
	// Idle bus at time zero
	initial begin
		cmd_valid = 1'b0;
		cmd_write = 1'b0;
		cmd_code = 8'h00;
		cmd_page = 1'b0;
		cmd_wdata = 16'h0000;
	end

	// Whole 16-bit word per command; idle lines inverted so stale data shows
	task automatic xfer(input logic w, input logic [7:0] c, input logic p,
		input logic [15:0] d, output logic [15:0] q, output logic [1:0] ae);
		@(posedge ref_clk);
		#1;
		cmd_valid = 1'b1;
		cmd_write = w;
		cmd_code = c;
		cmd_page = p;
		cmd_wdata = d;
		@(posedge ref_clk);
		#1;
		q = cmd_rdata;
		ae = {cmd_ack, cmd_err};
		cmd_valid = 1'b0;
		cmd_write = ~w;
		cmd_code = ~c;
		cmd_page = ~p;
		cmd_wdata = ~d;
	endtask

	// Hold off set-point raises until recalculation ends, giving up after 1000 cycles
	task automatic wait_idle();
		int n;
		n = 0;
		while (common_mfr_status[6:5] !== 2'b11 && n < 1000) begin
			@(posedge ref_clk);
			#1;
			n++;
		end
	endtask
endmodule

// [tb/ovl_regs_props.sv]
// Concurrent checks for the output voltage set-point and limit bank.
// Assumes binding onto ovl_regs with ce held high by the bench.
`timescale 1ns/100ps

module ovl_regs_props
	import ovl_pkg::*;
#(
	parameter int OV_APPLY_CYC = OVL_OV_APPLY_CYC
) (
	input wire logic ref_clk,
	input wire logic resetn,
	input wire logic ce,
	input wire logic cmd_valid,
	input wire logic cmd_write,
	input wire logic [7:0] cmd_code,
	input wire logic cmd_page,
	input wire logic [15:0] cmd_wdata,
	input wire logic [15:0] cmd_rdata,
	input wire logic cmd_err,
	input wire logic cml_fault,
	input wire logic [1:0] pwm_mode_config_range,
	input wire logic [1:0] switching_active,
	input wire logic [1:0] overvolt_pulldown_response,
	input wire logic [1:0] readback_valid,
	input wire logic [1:0] alert_mask,
	input wire logic [15:0] vout_target_0,
	input wire logic [7:0] common_mfr_status,
	input wire logic [1:0] ov_fault,
	input wire logic [1:0] uv_fault,
	input wire logic [1:0] top_gate_drive,
	input wire logic [1:0] bottom_gate_drive,
	input wire logic fault_pin_n,
	input wire logic [1:0] status_other,
	input wire logic [1:0] status_vout,
	input wire logic [1:0] ov_warn,
	input wire logic [1:0] uv_warn,
	input wire logic alert_n
);
	// Busy window bound, small slack for the pulse edges
	localparam int BUSY_MAX = OV_APPLY_CYC + 2;
	logic rd;
	logic wr;
	logic [17:0] busy_len;

	// Request qualifiers shared by the properties
	assign rd = ce && cmd_valid && !cmd_write;
	assign wr = ce && cmd_valid && cmd_write;

	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!resetn);

	// ----
	// Command port
	// ----
	chk_format_read: assert property (rd && cmd_code == 8'h20
		|=> cmd_rdata == 16'h0014) else $error("format byte wrong");
	chk_readonly_refused: assert property (wr && (cmd_code == 8'h20
		|| cmd_code == 8'ha5) |=> cmd_err) else $error("read-only write taken");
	chk_abs_ceil_high: assert property (rd && cmd_code == 8'ha5
		&& !pwm_mode_config_range[cmd_page] |=> cmd_rdata == 16'h5b33)
		else $error("high range ceiling wrong");
	chk_abs_ceil_low: assert property (rd && cmd_code == 8'ha5
		&& pwm_mode_config_range[cmd_page] |=> cmd_rdata == 16'h2c00)
		else $error("low range ceiling wrong");
	chk_nominal_clamp_flag: assert property (wr && cmd_code == 8'h21
		&& cmd_wdata > (pwm_mode_config_range[cmd_page] ? 16'h2c00 : 16'h5b33)
		|=> cml_fault) else $error("missing logic fault");
	chk_target_capped: assert property (vout_target_0 <= 16'h5b33)
		else $error("target above ceiling");

	// ----
	// Busy bits and limits
	// ----
	chk_busy_on_write: assert property (wr && cmd_code == 8'h40
		&& switching_active[cmd_page] |=> common_mfr_status[6:5] == 2'b00)
		else $error("busy bits not low");
	// Length of the current busy stretch; a counter, since the real delay
	// runs far past what a delay range may span
	always_ff @(posedge ref_clk) begin
		if (!resetn || common_mfr_status[5]) begin
			busy_len <= 18'h00000;
		end else if (ce) begin
			busy_len <= busy_len + 18'h00001;
		end
	end
	chk_busy_bounded: assert property (busy_len <= 18'(BUSY_MAX))
		else $error("busy too long");
	chk_status_spare: assert property ((common_mfr_status & 8'h9f)
		== 8'h00) else $error("spare status bits set");
	chk_ov_gates: assert property ((ov_fault & top_gate_drive) == 2'b00
		&& (ov_fault & ~bottom_gate_drive) == 2'b00) else $error("gates");
	chk_fault_pin_cause: assert property (!fault_pin_n |-> |uv_fault
		|| |(ov_fault & ~$past(overvolt_pulldown_response)))
		else $error("fault pin without cause");

	// Rising warning on channel 0
	chk_warn_status: assert property ($rose(ov_warn[0]) || $rose(uv_warn[0])
		|-> status_other[0] && status_vout[0]) else $error("status bits");
	chk_warn_alert: assert property (($rose(ov_warn[0]) || $rose(uv_warn[0]))
		&& !$past(alert_mask[0]) |-> !alert_n) else $error("alert missing");
	chk_warn_cause: assert property ($rose(ov_warn[0])
		|-> $past(readback_valid[0])) else $error("warning without readback");

	cover property (ov_fault[0]);
	cover property (!alert_n);
	cover property ($fell(common_mfr_status[5]));
endmodule

bind ovl_regs ovl_regs_props #(.OV_APPLY_CYC(OV_APPLY_CYC)) u_ovl_regs_props (.*);

// [tb/tb.sv]
// Self-checking bench for the output voltage limit bank.
// Assumes ovl_host as command master and the bound property checker.
`timescale 1ns/100ps

module tb;
	import ovl_pkg::*;
	// Short busy window keeps the run brief
	localparam int OV_APPLY_CYC = 20;
	logic ref_clk, resetn, ce, cmd_valid, cmd_write, cmd_page, cmd_ack;
	logic cmd_err, cml_fault, clear_status, fault_pin_n, alert_n;
	logic [7:0] cmd_code, common_mfr_status;
	logic [15:0] cmd_wdata, cmd_rdata, ramp_step, q;
	logic [15:0] sense_volt_0, sense_volt_1, readback_volt_0, readback_volt_1;
	logic [15:0] vout_target_0, vout_target_1, iin_offset_0, iin_offset_1;
	logic [1:0] pwm_mode_config_range, op_mode_0, op_mode_1, seq_ramping, r;
	logic [1:0] out_active, switching_active, overvolt_pulldown_response;
	logic [1:0] readback_valid, pwm_top, pwm_bot, alert_mask, ov_fault;
	logic [1:0] uv_fault, top_gate_drive, bottom_gate_drive, status_other;
	logic [1:0] status_vout, ov_warn, uv_warn;
	int err_count = 0;
	int checks_done = 0;
	logic [7:0] codes [11] = '{8'h20, 8'h21, 8'h24, 8'h25, 8'h26, 8'h40,
		8'h42, 8'h43, 8'h44, 8'ha5, 8'he9};
	logic [15:0] dflt [11] = '{16'h0014, 16'h1000, 16'h599a, 16'h10cd,
		16'h0f33, 16'h119a, 16'h1133, 16'h0ecd, 16'h0e66, 16'h5b33, 16'h9333};
	// Channel 1 values chosen so later fault and warning cases still hold
	logic [7:0] wcode [7] = '{8'h25, 8'h26, 8'h42, 8'h43, 8'h44, 8'he9,
		8'h40};
	logic [15:0] wval [7] = '{16'h1100, 16'h0f00, 16'h1140, 16'h0f00,
		16'h0e80, 16'h9400, 16'h1200};

	ovl_regs #(.OV_APPLY_CYC(OV_APPLY_CYC)) u_ovl_regs (.*);
	ovl_host u_ovl_host (.*);

	// 25 MHz clock
	initial begin
		ref_clk = 1'b0;
		forever #20 ref_clk = ~ref_clk;
	end

	task automatic chk(input string nm, input logic [15:0] got,
		input logic [15:0] exp);
		checks_done++;
		if (got !== exp) begin
			err_count++;
			$display("MISMATCH %s expected %h seen %h", nm, exp, got);
		end
	endtask

	task automatic wr(input logic [7:0] c, input logic p, input logic [15:0] d,
		input logic [1:0] ae);
		u_ovl_host.xfer(1'b1, c, p, d, q, r);
		chk("write answer", 16'(r), 16'(ae));
	endtask

	task automatic rd(input logic [7:0] c, input logic p, input logic [15:0] e,
		input logic [1:0] ae);
		u_ovl_host.xfer(1'b0, c, p, 16'h0000, q, r);
		chk("read answer", 16'(r), 16'(ae));
		chk("read data", q, e);
	endtask

	task automatic step(input int n);
		repeat (n) @(posedge ref_clk);
		#1;
	endtask

	task automatic report_and_stop();
		if (err_count == 0 && checks_done > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	// Watchdog against a hung handshake
	initial begin
		repeat (5000) @(posedge ref_clk);
		err_count++;
		report_and_stop();
	end

	// ----
	// Main sequence
	// ----
	initial begin
		{ce, resetn, clear_status} = 3'b100;
		{pwm_mode_config_range, op_mode_0, op_mode_1, seq_ramping} = 8'h00;
		{out_active, switching_active, readback_valid, alert_mask} = 8'h00;
		{overvolt_pulldown_response, pwm_top, pwm_bot} = 6'b001100;
		ramp_step = 16'h0001;
		{sense_volt_0, sense_volt_1} = {16'h1000, 16'h1000};
		{readback_volt_0, readback_volt_1} = {16'h1000, 16'h1000};
		step(5);
		resetn = 1'b1;
		for (int p = 0; p < 2; p++) begin
			for (int i = 0; i < 11; i++) begin
				rd(codes[i], p[0], dflt[i], 2'b10);
			end
		end
		for (int i = 0; i < 7; i++) begin
			wr(wcode[i], 1'b1, wval[i], 2'b10);
			rd(wcode[i], 1'b1, wval[i], 2'b10);
		end
		chk("idle busy", 16'(common_mfr_status[6:5]), 16'h0003);
		chk("iin offset 1", iin_offset_1, 16'h9400);
		chk("iin offset 0", iin_offset_0, 16'h9333);
		wr(8'h20, 1'b0, 16'h0055, 2'b11);
		wr(8'ha5, 1'b0, 16'h0055, 2'b11);
		rd(8'h20, 1'b0, 16'h0014, 2'b10);
		rd(8'h30, 1'b0, 16'h0000, 2'b11);
		wr(8'h21, 1'b1, 16'h1200, 2'b10);
		rd(8'h21, 1'b0, 16'h1000, 2'b10);
		step(4);
		chk("target 1", vout_target_1, 16'h1200);
		// Margin values kept either side of nominal by the host
		op_mode_0 = 2'b10;
		step(4);
		chk("margin high", vout_target_0, 16'h10cd);
		op_mode_0 = 2'b01;
		step(4);
		chk("margin low", vout_target_0, 16'h0f33);
		wr(8'h24, 1'b0, 16'h6000, 2'b10);
		rd(8'h24, 1'b0, 16'h5b33, 2'b10);
		wr(8'h24, 1'b0, 16'h0c00, 2'b10);
		op_mode_0 = 2'b10;
		step(4);
		chk("capped margin", vout_target_0, 16'h0c00);
		op_mode_0 = 2'b00;
		wr(8'h24, 1'b0, 16'h599a, 2'b10);
		pwm_mode_config_range = 2'b01;
		rd(8'ha5, 1'b0, 16'h2c00, 2'b10);
		rd(8'ha5, 1'b1, 16'h5b33, 2'b10);
		wr(8'h21, 1'b0, 16'h3000, 2'b10);
		chk("logic fault", 16'(cml_fault), 16'h0001);
		rd(8'h21, 1'b0, 16'h2c00, 2'b10);
		pwm_mode_config_range = 2'b00;
		wr(8'h21, 1'b0, 16'h1000, 2'b10);
		step(4);
		out_active = 2'b01;
		wr(8'h21, 1'b0, 16'h1040, 2'b10);
		step(8);
		chk("ramp midway", 16'(vout_target_0 < 16'h1040), 16'h0001);
		step(80);
		chk("ramp end", vout_target_0, 16'h1040);
		seq_ramping = 2'b01;
		wr(8'h21, 1'b0, 16'h0f00, 2'b10);
		step(8);
		chk("sequencing hold", vout_target_0, 16'h1040);
		{seq_ramping, out_active} = 4'h0;
		switching_active = 2'b01;
		wr(8'h40, 1'b0, 16'h1300, 2'b10);
		chk("busy", 16'(common_mfr_status[6:5]), 16'h0000);
		step(OV_APPLY_CYC + 2);
		chk("busy end", 16'(common_mfr_status[6:5]), 16'h0003);
		u_ovl_host.wait_idle();
		chk("idle wait", 16'(common_mfr_status[6:5]), 16'h0003);
		wr(8'h21, 1'b0, 16'h11a0, 2'b10);
		sense_volt_0 = 16'h1400;
		step(2);
		chk("ov fault", 16'(ov_fault), 16'h0001);
		chk("gates", 16'({top_gate_drive[0], bottom_gate_drive[0]}), 16'h1);
		chk("fault pin", 16'(fault_pin_n), 16'h0000);
		overvolt_pulldown_response = 2'b01;
		step(2);
		chk("pulldown pin", 16'(fault_pin_n), 16'h0001);
		{sense_volt_0, sense_volt_1} = {16'h0e00, 16'h0e00};
		step(2);
		chk("uv fault", 16'({ov_fault, uv_fault}), 16'h0003);
		chk("uv pin", 16'(fault_pin_n), 16'h0000);
		{sense_volt_0, sense_volt_1} = {16'h1000, 16'h1000};
		readback_volt_0 = 16'h1140;
		readback_valid = 2'b01;
		step(1);
		readback_valid = 2'b00;
		step(1);
		chk("ov warn", 16'(ov_warn), 16'h0001);
		chk("ov flags", 16'({status_other[0], status_vout[0], alert_n}), 16'h6);
		clear_status = 1'b1;
		step(1);
		clear_status = 1'b0;
		step(1);
		chk("cleared", 16'({ov_warn, alert_n}), 16'h0001);
		alert_mask = 2'b11;
		{readback_volt_0, readback_volt_1} = {16'h0e00, 16'h0e00};
		readback_valid = 2'b11;
		step(1);
		readback_valid = 2'b00;
		step(1);
		chk("uv warn", 16'({uv_warn, status_vout}), 16'h000f);
		chk("masked alert", 16'(alert_n), 16'h0001);
		report_and_stop();
	end
endmodule
